//--- common/hb_decoder_pkg.sv
// shared constants for the half-bridge input decoder
package hb_decoder_pkg;

  // ======================================================================
  // register map (byte addresses, one 32-bit word each)
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_PHASE  = 8'h08;

  // control register field positions
  localparam int CTRL_SCHEME_LSB = 0;
  localparam int CTRL_BUCKV_LSB  = 2;
  localparam int CTRL_BUCK_OFF   = 4;
  localparam int CTRL_BUCK_LIM   = 5;
  localparam int CTRL_SEQ_OFF    = 6;
  localparam int CTRL_STRAP_VAR  = 7;

  // values after reset
  localparam logic [1:0] SCHEME_RESET = 2'h0;
  localparam logic [1:0] BUCKV_RESET  = 2'h0;
  localparam logic       SEQ_OFF_RST  = 1'h1;

  // ======================================================================
  // drive schemes
  typedef enum logic [1:0] {
    SCHEME_SIX      = 2'b00,
    SCHEME_SIX_CL   = 2'b01,
    SCHEME_THREE    = 2'b10,
    SCHEME_THREE_CL = 2'b11
  } scheme_t;

  // strap levels of the four-level scheme pin
  typedef enum logic [1:0] {
    STRAP_GND   = 2'b00,
    STRAP_FLOAT = 2'b01,
    STRAP_RES   = 2'b10,
    STRAP_RAIL  = 2'b11
  } strap_t;

  // buck targets: 3.3 V, 5.0 V, 4.0 V, 5.7 V
  typedef enum logic [1:0] {
    BUCK_3V3 = 2'b00,
    BUCK_5V0 = 2'b01,
    BUCK_4V0 = 2'b10,
    BUCK_5V7 = 2'b11
  } buck_volt_t;

  // phase output state encoding
  typedef enum logic [1:0] {
    PH_HIZ  = 2'b00,
    PH_LOW  = 2'b01,
    PH_HIGH = 2'b10
  } phase_t;

endpackage

//--- verilog/phase_decode.sv
// one phase: command decode plus cycle-by-cycle current limit latch
`timescale 1ns/10ps
module phase_decode (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    high_side_cmd_in_i,
  input  wire logic                    low_side_cmd_in_i,
  input  wire hb_decoder_pkg::scheme_t scheme_i,
  input  wire logic                    limit_trip_i,
  output logic [1:0]                   phase_output_state_o,
  output logic                         limited_o
);
  import hb_decoder_pkg::*;

  logic   three_in;
  logic   limit_en;
  phase_t raw_state;
  logic   active;
  logic   active_q;
  logic   rise;
  logic   lim_q;
  logic   lim_d;
  phase_t out_d;

  // ======================================================================
  // decode
  assign three_in = (scheme_i == SCHEME_THREE) ||
                    (scheme_i == SCHEME_THREE_CL);
  assign limit_en = (scheme_i == SCHEME_SIX_CL) ||
                    (scheme_i == SCHEME_THREE_CL);

  // six-input truth table and three-input truth table
  assign raw_state = three_in ?
      (!low_side_cmd_in_i ? PH_HIZ :
       (high_side_cmd_in_i ? PH_HIGH : PH_LOW)) :
      ((high_side_cmd_in_i == low_side_cmd_in_i) ? PH_HIZ :
       (high_side_cmd_in_i ? PH_HIGH : PH_LOW));

  // an active command edge starts a new pwm period
  assign active = (raw_state == PH_HIGH);
  assign rise   = active && !active_q;

  // trip latches off until the next active edge
  // a trip in the same cycle as the edge still wins over the clear
  assign lim_d = !limit_en ? 1'b0 :
                 (limit_trip_i && active) ? 1'b1 :
                 rise      ? 1'b0 : lim_q;

  assign out_d = (lim_d && active) ? PH_HIZ : raw_state;

  // ======================================================================
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_q             <= 1'b0;
      lim_q                <= 1'b0;
      phase_output_state_o <= PH_HIZ;
    end else begin
      active_q             <= active;
      lim_q                <= lim_d;
      phase_output_state_o <= out_d;
    end
  end

  assign limited_o = lim_q;

  // ======================================================================
  // checks
  property p_six_high;
    @(posedge clk_i) disable iff (rst_i)
      (scheme_i == SCHEME_SIX && high_side_cmd_in_i && !low_side_cmd_in_i)
      |=> phase_output_state_o == PH_HIGH;
  endproperty
  a_six_high: assert property (p_six_high)
    else $error("six-input high not driven");

  property p_six_both;
    @(posedge clk_i) disable iff (rst_i)
      (!three_in && high_side_cmd_in_i && low_side_cmd_in_i)
      |=> phase_output_state_o == PH_HIZ;
  endproperty
  a_six_both: assert property (p_six_both)
    else $error("six-input both high not hi-z");

  property p_three_hiz;
    @(posedge clk_i) disable iff (rst_i)
      (three_in && !low_side_cmd_in_i) |=> phase_output_state_o == PH_HIZ;
  endproperty
  a_three_hiz: assert property (p_three_hiz)
    else $error("three-input low enable not hi-z");

  property p_three_low;
    @(posedge clk_i) disable iff (rst_i)
      (three_in && low_side_cmd_in_i && !high_side_cmd_in_i)
      |=> phase_output_state_o == PH_LOW;
  endproperty
  a_three_low: assert property (p_three_low)
    else $error("three-input low not driven");

  property p_no_limit;
    @(posedge clk_i) disable iff (rst_i)
      !limit_en |=> !lim_q;
  endproperty
  a_no_limit: assert property (p_no_limit)
    else $error("limiting in a plain scheme");

  property p_trip_hold;
    @(posedge clk_i) disable iff (rst_i)
      (limit_en && limit_trip_i && active && !rise) ##1
      (limit_en && active && !rise) |=> phase_output_state_o == PH_HIZ;
  endproperty
  a_trip_hold: assert property (p_trip_hold)
    else $error("trip did not hold phase off");
endmodule

//--- verilog/wb_regs.sv
// classic wishbone slave holding control and reporting status
`timescale 1ns/10ps
module wb_regs (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  input  wire logic [31:0] status_i,
  input  wire logic [31:0] phase_i,
  output logic [7:0]       ctrl_o
);
  import hb_decoder_pkg::*;

  logic        req;
  logic        wr_ctrl;
  logic [31:0] rd_mux;
  logic [7:0]  ctrl_q;

  // ======================================================================
  // decode; one-cycle ack, dropped the cycle after
  assign req     = cyc_i && stb_i && !ack_o;
  assign wr_ctrl = req && we_i && sel_i[0] && (adr_i == ADDR_CTRL);
  assign rd_mux  = (adr_i == ADDR_CTRL)   ? {24'h0, ctrl_q} :
                   (adr_i == ADDR_STATUS) ? status_i :
                   (adr_i == ADDR_PHASE)  ? phase_i : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= {1'b0, SEQ_OFF_RST, 1'b0, 1'b0, BUCKV_RESET, SCHEME_RESET};
      ack_o  <= 1'b0;
      dat_o  <= 32'h0;
    end else begin
      ack_o <= req;
      if (wr_ctrl) begin
        ctrl_q <= dat_i[7:0];
      end
      if (req) begin
        dat_o <= rd_mux;
      end
    end
  end

  assign ctrl_o = ctrl_q;
endmodule

//--- verilog/hb_input_decoder.sv
// top: three-phase command decoder with scheme and buck control
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
module hb_input_decoder #(
  parameter int PHASES = 3
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [7:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic [31:0]            dat_o,
  output logic                   ack_o,
  // variant strap: 1 selects the strap-configured part
  input  wire logic              strap_variant_i,
  // pwm command inputs
  input  wire logic [PHASES-1:0] high_side_cmd_in_i,
  input  wire logic [PHASES-1:0] low_side_cmd_in_i,
  // current sense comparator results, one per amplifier
  input  wire logic [PHASES-1:0] sense_over_i,
  // shared serial / strap pins, strap levels as two-bit codes
  input  wire logic              serial_select_n_i,
  input  wire logic              serial_clk_i,
  input  wire logic              serial_din_i,
  input  wire logic [1:0]        gain_strap_i,
  input  wire logic [1:0]        slew_strap_i,
  input  wire hb_decoder_pkg::strap_t scheme_strap_i,
  input  wire logic [1:0]        ocp_strap_i,
  input  wire hb_decoder_pkg::buck_volt_t buck_voltage_strap_i,
  input  wire logic              fault_i,
  // outputs
  output logic [2*PHASES-1:0]    phase_output_state_o,
  output logic                   serial_dout_o,
  output logic                   serial_dout_oe_n_o,
  output logic                   serial_active_o,
  output logic                   fault_out_n_o,
  output logic                   fault_out_oe_n_o,
  output logic [1:0]             gain_sel_o,
  output logic [1:0]             slew_sel_o,
  output logic [1:0]             ocp_sel_o,
  output hb_decoder_pkg::buck_volt_t buck_volt_o,
  output logic                   buck_enable_o,
  output logic                   buck_limit_select_o,
  output logic                   ldo_from_buck_o
);
  import hb_decoder_pkg::*;

  // refuse phase counts that the status word cannot report
  generate
    if (PHASES < 1 || PHASES > 8) begin : g_bad_phases
      $error("PHASES must be 1 to 8");
    end
  endgenerate

  logic [7:0]        ctrl;
  logic              strap_q;
  scheme_t           scheme_reg;
  scheme_t           scheme_strap;
  scheme_t           scheme;
  buck_volt_t        buck_sel;
  logic              buck_off_bit;
  logic              ldo_sequencing_off_bit;
  logic              seq_allowed;
  logic              limit_trip;
  logic [PHASES-1:0] limited;
  logic [31:0]       status_word;
  logic [31:0]       phase_word;
  logic              sel_q;
  logic              sdo_q;

  // ======================================================================
  // register file
  wb_regs u_regs (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .cyc_i    (cyc_i),
    .stb_i    (stb_i),
    .we_i     (we_i),
    .adr_i    (adr_i),
    .sel_i    (sel_i),
    .dat_i    (dat_i),
    .dat_o    (dat_o),
    .ack_o    (ack_o),
    .status_i (status_word),
    .phase_i  (phase_word),
    .ctrl_o   (ctrl)
  );

  // ======================================================================
  // variant strap registered every cycle once reset is released
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_q <= 1'b0;
    end else begin
      strap_q <= strap_variant_i;
    end
  end

  // ======================================================================
  // scheme select: register field or four-level strap pin
  assign scheme_reg = scheme_t'(ctrl[CTRL_SCHEME_LSB +: 2]);
  assign scheme_strap =
      (scheme_strap_i == STRAP_GND)   ? SCHEME_SIX :
      (scheme_strap_i == STRAP_RES)   ? SCHEME_THREE :
      (scheme_strap_i == STRAP_FLOAT) ? SCHEME_SIX_CL :
                                        SCHEME_THREE_CL;
  assign scheme = strap_q ? scheme_strap : scheme_reg;

  // ======================================================================
  // one comparator result from all three sense amplifiers
  assign limit_trip = |sense_over_i;

  // ======================================================================
  // per-phase decoders
  genvar g;
  generate
    for (g = 0; g < PHASES; g++) begin : g_phase
      phase_decode u_phase (
        .clk_i                (clk_i),
        .rst_i                (rst_i),
        .high_side_cmd_in_i   (high_side_cmd_in_i[g]),
        .low_side_cmd_in_i    (low_side_cmd_in_i[g]),
        .scheme_i             (scheme),
        .limit_trip_i         (limit_trip),
        .phase_output_state_o (phase_output_state_o[2*g +: 2]),
        .limited_o            (limited[g])
      );
    end
  endgenerate

  // ======================================================================
  // buck controls
  assign buck_sel = strap_q ? buck_voltage_strap_i
                            : buck_volt_t'(ctrl[CTRL_BUCKV_LSB +: 2]);
  assign buck_off_bit           = ctrl[CTRL_BUCK_OFF];
  assign ldo_sequencing_off_bit = ctrl[CTRL_SEQ_OFF];
  assign seq_allowed = (buck_sel == BUCK_5V0) ||
                       (buck_sel == BUCK_5V7);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buck_volt_o         <= BUCK_3V3;
      buck_enable_o       <= 1'b0;
      buck_limit_select_o <= 1'b0;
      ldo_from_buck_o     <= 1'b0;
    end else begin
      buck_volt_o         <= buck_sel;
      buck_enable_o       <= strap_q || !buck_off_bit;
      buck_limit_select_o <= strap_q ? 1'b0
                                     : ctrl[CTRL_BUCK_LIM];
      ldo_from_buck_o     <= !ldo_sequencing_off_bit && seq_allowed &&
                             (strap_q || !buck_off_bit);
    end
  end

  // ======================================================================
  // shared pins: straps or serial
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_sel_o <= 2'h0;
      slew_sel_o <= 2'h0;
      ocp_sel_o  <= 2'h0;
      sel_q      <= 1'b0;
      sdo_q      <= 1'b1;
    end else begin
      gain_sel_o <= strap_q ? gain_strap_i : 2'h0;
      slew_sel_o <= strap_q ? slew_strap_i : 2'h0;
      ocp_sel_o  <= strap_q ? ocp_strap_i  : 2'h0;
      sel_q      <= !strap_q && !serial_select_n_i;
      // echo input data while selected and the serial clock is high; framing is outside this block
      sdo_q      <= (!strap_q && !serial_select_n_i && serial_clk_i) ?
                    serial_din_i : sdo_q;
    end
  end

  assign serial_active_o    = sel_q;
  // open drain: pin pulled low or released, never driven high
  assign serial_dout_o      = 1'b0;
  assign serial_dout_oe_n_o = !(sel_q && !sdo_q);

  // fault pin reports faults on both parts; the status word also carries them
  assign fault_out_n_o    = 1'b0;
  assign fault_out_oe_n_o = !fault_i;

  // ======================================================================
  // status words
  assign status_word = {22'h0, strap_q, fault_i, 8'(limited)};
  assign phase_word  = 32'(phase_output_state_o);

  // ======================================================================
  // checks
  property p_seq_block;
    @(posedge clk_i) disable iff (rst_i)
      !seq_allowed |=> !ldo_from_buck_o;
  endproperty
  a_seq_block: assert property (p_seq_block)
    else $error("sequencing at a low buck target");

  property p_strap_buck_on;
    @(posedge clk_i) disable iff (rst_i)
      strap_q |=> buck_enable_o;
  endproperty
  a_strap_buck_on: assert property (p_strap_buck_on)
    else $error("buck disabled on strap part");

  property p_sdo_quiet;
    @(posedge clk_i) disable iff (rst_i)
      serial_select_n_i ##1 1'b1 |-> serial_dout_oe_n_o;
  endproperty
  a_sdo_quiet: assert property (p_sdo_quiet)
    else $error("serial out pulled while not selected");

  property p_strap_mode;
    @(posedge clk_i) disable iff (rst_i)
      (strap_q && scheme_strap_i == STRAP_RES) |-> scheme == SCHEME_THREE;
  endproperty
  a_strap_mode: assert property (p_strap_mode)
    else $error("resistor strap not three-input");

  property p_strap_gnd;
    @(posedge clk_i) disable iff (rst_i)
      (strap_q && scheme_strap_i == STRAP_GND) |-> scheme == SCHEME_SIX;
  endproperty
  a_strap_gnd: assert property (p_strap_gnd)
    else $error("grounded strap not six-input");

  property p_strap_float;
    @(posedge clk_i) disable iff (rst_i)
      (strap_q && scheme_strap_i == STRAP_FLOAT) |-> scheme == SCHEME_SIX_CL;
  endproperty
  a_strap_float: assert property (p_strap_float)
    else $error("floating strap not limited six-input");

  property p_strap_rail;
    @(posedge clk_i) disable iff (rst_i)
      (strap_q && scheme_strap_i == STRAP_RAIL) |-> scheme == SCHEME_THREE_CL;
  endproperty
  a_strap_rail: assert property (p_strap_rail)
    else $error("rail strap not limited three-input");

  property p_buck_volt;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> buck_volt_o == $past(buck_sel);
  endproperty
  a_buck_volt: assert property (p_buck_volt)
    else $error("buck target not passed on");

  property p_buck_off;
    @(posedge clk_i) disable iff (rst_i)
      (!strap_q && buck_off_bit) |=> !buck_enable_o;
  endproperty
  a_buck_off: assert property (p_buck_off)
    else $error("buck still on with off bit set");

  property p_strap_limit;
    @(posedge clk_i) disable iff (rst_i)
      strap_q |=> !buck_limit_select_o;
  endproperty
  a_strap_limit: assert property (p_strap_limit)
    else $error("reduced buck limit on strap part");

  property p_seq_on;
    @(posedge clk_i) disable iff (rst_i)
      (!ldo_sequencing_off_bit && seq_allowed && !buck_off_bit)
      |=> ldo_from_buck_o;
  endproperty
  a_seq_on: assert property (p_seq_on)
    else $error("sequencing enabled but ldo not on buck");

  property p_strap_pins;
    @(posedge clk_i) disable iff (rst_i)
      strap_q |=> gain_sel_o == $past(gain_strap_i);
  endproperty
  a_strap_pins: assert property (p_strap_pins)
    else $error("gain strap not read on strap part");

  property p_fault_pin;
    @(posedge clk_i) disable iff (rst_i)
      fault_i |-> !fault_out_oe_n_o;
  endproperty
  a_fault_pin: assert property (p_fault_pin)
    else $error("fault not shown on fault pin");
endmodule

//--- sim/pwm_ctrl_model.sv
// behavioural pwm controller driving the decoder command inputs
`timescale 1ns/10ps
module pwm_ctrl_model (
  input  wire logic       clk_i,
  input  wire logic       idle_i,
  input  wire logic [2:0] hi_i,
  input  wire logic [2:0] lo_i,
  output logic [2:0]      high_side_cmd_in_o,
  output logic [2:0]      low_side_cmd_in_o
);
  // ======================================================================
  // command launch
  // idle is high from time zero, so commands settle low within reset
  // commands change just after each rising edge
  always @(posedge clk_i) begin
    // idle pulls every command low before a scheme change
    high_side_cmd_in_o <= idle_i ? 3'h0 : hi_i;
    // three-input callers may hold low commands high for no hi-z
    low_side_cmd_in_o  <= idle_i ? 3'h0 : lo_i;
  end
endmodule

//--- sim/tb_half_bridge_input_decoder.sv
// self-checking bench for the half-bridge input decoder
`timescale 1ns/10ps
module tb_half_bridge_input_decoder;
  import hb_decoder_pkg::*;
  // ======================================================================
  // stimulus and observed signals
  logic        clk_i, rst_i, cyc, stb, we, sdn, sclk, sdin, fault, strap_v;
  logic        idle, ack, sdo, sdo_oe_n, sact, fo_n, fo_oe_n;
  logic        ben, blim, ldo;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q, lfsr_q;
  logic [2:0]  hs, ls, hreq, lreq, sense;
  logic [1:0]  gst, sst, ost, gsel, ssel, osel;
  logic [5:0]  phase;
  strap_t      sch_st;
  buck_volt_t  bv_st, bvolt;
  int          bad_count, comparisons, cur_s;

  // ======================================================================
  // design and controller model
  hb_input_decoder #(.PHASES(3)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .strap_variant_i(strap_v), .high_side_cmd_in_i(hs),
    .low_side_cmd_in_i(ls), .sense_over_i(sense),
    .serial_select_n_i(sdn), .serial_clk_i(sclk), .serial_din_i(sdin),
    .gain_strap_i(gst), .slew_strap_i(sst), .scheme_strap_i(sch_st),
    .ocp_strap_i(ost), .buck_voltage_strap_i(bv_st), .fault_i(fault),
    .phase_output_state_o(phase), .serial_dout_o(sdo),
    .serial_dout_oe_n_o(sdo_oe_n), .serial_active_o(sact),
    .fault_out_n_o(fo_n), .fault_out_oe_n_o(fo_oe_n), .gain_sel_o(gsel),
    .slew_sel_o(ssel), .ocp_sel_o(osel), .buck_volt_o(bvolt),
    .buck_enable_o(ben), .buck_limit_select_o(blim),
    .ldo_from_buck_o(ldo)
  );
  pwm_ctrl_model u_ctrl (
    .clk_i(clk_i), .idle_i(idle), .hi_i(hreq), .lo_i(lreq),
    .high_side_cmd_in_o(hs), .low_side_cmd_in_o(ls)
  );

  // ======================================================================
  // helpers
  // 100 mhz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // watchdog cuts a hung run short
  initial begin
    #500000;
    bad_count++;
    $display("watchdog expired");
    report_and_stop();
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected phase word: 00 hi-z, 01 low, 10 high per phase
  function automatic logic [5:0] exp_ph(logic [2:0] h, logic [2:0] l,
                                        logic t);
    logic [5:0] e;
    int         v;
    for (int p = 0; p < 3; p++) begin
      if (cur_s / 2 == 0) v = (h[p] && !l[p]) ? 2 : (!h[p] && l[p]) ? 1 : 0;
      else v = !l[p] ? 0 : h[p] ? 2 : 1;
      if (t && cur_s % 2 == 1 && v == 2) v = 0;
      e[2*p +: 2] = v[1:0];
    end
    return e;
  endfunction
  task chk(input string what, input logic [31:0] seen,
           input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // one classic wishbone cycle, read data left in q
  // waits for ack however long it takes; only the watchdog ends a hang
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // idle, drive commands, trip the comparator, release it
  task run(input logic [2:0] h, input logic [2:0] l, input logic [2:0] t);
    @(posedge clk_i);
    idle <= 1'b1;
    step(3);
    @(posedge clk_i);
    idle <= 1'b0;
    hreq <= h;
    lreq <= l;
    step(3);
    chk("phase", phase, exp_ph(h, l, 1'b0));
    @(posedge clk_i);
    sense <= t;
    step(3);
    chk("phase trip", phase, exp_ph(h, l, 1'b1));
    @(posedge clk_i);
    sense <= 3'h0;
    step(3);
    chk("phase held", phase, exp_ph(h, l, 1'b1));
  endtask
  task report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ======================================================================
  // main sequence
  initial begin
    {cyc, stb, we, sdn, sclk, sdin, fault, strap_v} = 8'h10;
    {adr, wdat, hreq, lreq, sense, gst, sst, ost} = '0;
    sch_st = STRAP_GND;
    bv_st = BUCK_3V3;
    idle = 1'b1;
    lfsr_q = 32'h41a5;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // register reset values and an unmapped place
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", q, 32'h40);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk("status reset", q, 32'h0);
    wb(1'b1, 8'h0c, 32'hff);
    wb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", q, 32'h0);
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl kept", q, 32'h40);
    $display("test registers done");
    // every scheme against every command pair
    for (int s = 0; s < 4; s++) begin
      cur_s = s;
      @(posedge clk_i);
      idle <= 1'b1;
      step(3);
      wb(1'b1, ADDR_CTRL, 32'h40 | s);
      for (int k = 0; k < 64; k++) begin
        lfsr_q = lfsr(lfsr_q);
        run(k[2:0], k[5:3], 3'h1 << (lfsr_q % 3));
      end
      $display("test scheme %0d done", s);
    end
    // buck target, off, limit and sequencing; bridge idled first
    @(posedge clk_i);
    idle <= 1'b1;
    step(3);
    for (int v = 0; v < 4; v++) begin
      wb(1'b1, ADDR_CTRL, v << 2);
      wb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl rw", q, v << 2);
      step(2);
      chk("buck volt", bvolt, v);
      chk("ldo seq", ldo, v == 1 || v == 3);
      chk("buck on", ben, 1'b1);
    end
    wb(1'b1, ADDR_CTRL, 32'h34);
    step(2);
    chk("buck off", ben, 1'b0);
    chk("limit 150", blim, 1'b1);
    wb(1'b1, ADDR_CTRL, 32'h44);
    step(2);
    chk("limit 600", blim, 1'b0);
    chk("seq off", ldo, 1'b0);
    $display("test buck done");
    // serial select, open-drain data and fault pin
    @(posedge clk_i);
    sdn  <= 1'b0;
    sclk <= 1'b1;
    sdin <= lfsr_q[0];
    step(2);
    chk("select", sact, 1'b1);
    chk("sdo level", sdo, 1'b0);
    chk("sdo drive", sdo_oe_n, lfsr_q[0]);
    @(posedge clk_i);
    sdn   <= 1'b1;
    fault <= 1'b1;
    step(2);
    chk("deselect", sact, 1'b0);
    chk("sdo released", sdo_oe_n, 1'b1);
    chk("fault pin", {fo_n, fo_oe_n}, 2'b00);
    $display("test pins done");
    // strap-configured part
    wb(1'b1, ADDR_CTRL, 32'h30);
    @(posedge clk_i);
    strap_v <= 1'b1;
    for (int st = 0; st < 4; st++) begin
      lfsr_q = lfsr(lfsr_q);
      @(posedge clk_i);
      idle <= 1'b1;
      step(2);
      @(posedge clk_i);
      sch_st <= strap_t'(st);
      bv_st  <= buck_volt_t'(st);
      {gst, sst, ost} <= lfsr_q[5:0];
      cur_s = st;
      step(3);
      chk("gain", gsel, lfsr_q[5:4]);
      chk("slew", ssel, lfsr_q[3:2]);
      chk("ocp", osel, lfsr_q[1:0]);
      chk("strap volt", bvolt, st);
      chk("strap buck on", ben, 1'b1);
      run(3'h5, 3'h3, 3'h4);
    end
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk("strap flag", q[9], 1'b1);
    $display("test strap done");
    report_and_stop();
  end
endmodule
